// ---- rtl/ostsc_defs.vh ----
// Purpose: constants of the one-shot timer start/stop control
// Assumes: byte-wide registers on a plain strobe port
// Notes: offsets are byte indexes on the register port
`ifndef OSTSC_DEFS_VH
`define OSTSC_DEFS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define OSTSC_ADDR_W 3
`define OSTSC_OFF_MODE 3'h0
`define OSTSC_OFF_PRESC 3'h1
`define OSTSC_OFF_SECRLD 3'h2
`define OSTSC_OFF_PRIRLD 3'h3
`define OSTSC_OFF_OSCTL 3'h4
`define OSTSC_OFF_PUM 3'h5
`define OSTSC_OFF_CNT 3'h6

// ****************************************************************
// field positions
// ****************************************************************
`define OSTSC_MODE_SEL_LO 4
`define OSTSC_MODE_SEL_HI 5
`define OSTSC_MODE_START 7
`define OSTSC_OS_START 0
`define OSTSC_PUM_LEVEL 0
`define OSTSC_PUM_TRGEN 1
`define OSTSC_PUM_TRGPOL 2

// ****************************************************************
// mode codes and reset values
// ****************************************************************
`define OSTSC_OPM_TIMER 2'h0
`define OSTSC_OPM_PWM 2'h1
`define OSTSC_OPM_ONESHOT 2'h2
`define OSTSC_OPM_WAIT 2'h3
`define OSTSC_RST_MODE 8'h00
`define OSTSC_RST_PUM 8'h00
`define OSTSC_RST_RLD 8'hFF
`endif

// ---- rtl/ostsc_edge_det.v ----
// Purpose: edge detect of the external trigger pin
// Assumes: pin already synchronous to sys_clk
// Notes: fires on the edge picked by the polarity input
`timescale 1ns/100ps
module ostsc_edge_det (
   sys_clk,
   nrst,
   clkEn,
   pinIn,
   riseSel,
   edgeHit
);
   input wire sys_clk;
   input wire nrst;
   input wire clkEn;
   input wire pinIn;
   input wire riseSel;
   output wire edgeHit;

   reg pinDly_r;

   // ****************************************************************
   // pin delay stage
   // ****************************************************************
   // one pulse per edge; idle high avoids a false rise after reset
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         pinDly_r <= 1'b1;
      else if (clkEn)
         pinDly_r <= pinIn;
   end

   // 0 takes the falling edge, 1 the rising edge
   assign edgeHit = riseSel ? (pinIn & ~pinDly_r) :
                              (~pinIn & pinDly_r);
endmodule

// ---- rtl/ostsc_top.v ----
// Purpose: start/stop control of a prescaled one-shot timer
// Assumes: register port synchronous to sys_clk, srcTick one cycle
// Notes: counting is simplified; the start bit handshakes on srcTick
`timescale 1ns/100ps
`include "ostsc_defs.vh"
module ostsc_top (
   sys_clk,
   nrst,
   clkEn,
   srcTick,
   regAddr,
   regWdata,
   regWr,
   regRd,
   regRdata,
   extPin,
   pulseOut,
   underflow
);
   parameter DW = 8;
   input wire sys_clk;
   input wire nrst;
   input wire clkEn;
   input wire srcTick;
   input wire [`OSTSC_ADDR_W-1:0] regAddr;
   input wire [DW-1:0] regWdata;
   input wire regWr;
   input wire regRd;
   output reg [DW-1:0] regRdata;
   input wire extPin;
   output reg pulseOut;
   output reg underflow;

   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_FIRE = 3'b100;

   reg [DW-1:0] mode_r;
   reg [DW-1:0] pum_r;
   reg [DW-1:0] presc_r;
   reg [DW-1:0] secRld_r;
   reg [DW-1:0] priRld_r;
   reg [DW-1:0] pre_r;
   reg [DW-1:0] cnt_r;
   reg startReq_r;
   reg running_r;
   reg osReq_r;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   wire [1:0] opMode;
   wire oneShotMode;
   wire pinHit;
   wire osStart;
   wire wrMode;

   // true when the address equals a given offset
   function hit;
      input [`OSTSC_ADDR_W-1:0] a;
      input [`OSTSC_ADDR_W-1:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   assign opMode = {mode_r[`OSTSC_MODE_SEL_HI], mode_r[`OSTSC_MODE_SEL_LO]};
   assign oneShotMode = (opMode == `OSTSC_OPM_ONESHOT) ||
                        (opMode == `OSTSC_OPM_WAIT);
   assign wrMode = regWr && hit(regAddr, `OSTSC_OFF_MODE);

   ostsc_edge_det uEdge (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .clkEn(clkEn),
      .pinIn(extPin),
      .riseSel(pum_r[`OSTSC_PUM_TRGPOL]),
      .edgeHit(pinHit)
   );

   // pin may fire only when enabled and the timer runs one-shot
   assign osStart = (pinHit & pum_r[`OSTSC_PUM_TRGEN]) | osReq_r;

   // ****************************************************************
   // register writes
   // ****************************************************************
   // the start bit is kept out of mode_r: the request lives apart
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mode_r <= `OSTSC_RST_MODE;
         pum_r <= `OSTSC_RST_PUM;
         presc_r <= `OSTSC_RST_RLD;
         secRld_r <= `OSTSC_RST_RLD;
         priRld_r <= `OSTSC_RST_RLD;
         startReq_r <= 1'b0;
      end else if (clkEn && regWr) begin
         if (hit(regAddr, `OSTSC_OFF_MODE)) begin
            mode_r <= regWdata & ~(8'h80);
            startReq_r <= regWdata[`OSTSC_MODE_START];
         end
         if (hit(regAddr, `OSTSC_OFF_PRESC))
            presc_r <= regWdata;
         if (hit(regAddr, `OSTSC_OFF_SECRLD))
            secRld_r <= regWdata;
         if (hit(regAddr, `OSTSC_OFF_PRIRLD))
            priRld_r <= regWdata;
         if (hit(regAddr, `OSTSC_OFF_PUM))
            pum_r <= regWdata & 8'h07;
      end
   end

   // ****************************************************************
   // one-shot start bit
   // ****************************************************************
   // a write wins over the hardware clear at the first counted tick
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         osReq_r <= 1'b0;
      else if (clkEn) begin
         if (regWr && hit(regAddr, `OSTSC_OFF_OSCTL))
            osReq_r <= regWdata[`OSTSC_OS_START];
         else if (state_r == ST_FIRE && running_r && srcTick)
            osReq_r <= 1'b0;
      end
   end

   // ****************************************************************
   // run state and one-shot sequence
   // ****************************************************************
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
            if (running_r && oneShotMode && osStart)
               state_nxt = ST_WAIT;
         ST_WAIT:
            if (!running_r)
               state_nxt = ST_IDLE;
            else if (srcTick)
               state_nxt = ST_FIRE;
         ST_FIRE:
            if (!running_r)
               state_nxt = ST_IDLE;
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   // running follows the request only on a count-source tick
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         running_r <= 1'b0;
         state_r <= ST_IDLE;
         pre_r <= `OSTSC_RST_RLD;
         cnt_r <= `OSTSC_RST_RLD;
         underflow <= 1'b0;
      end else if (clkEn) begin
         underflow <= 1'b0;
         state_r <= state_nxt;
         if (srcTick)
            running_r <= startReq_r;
         if (oneShotMode && (!startReq_r ||
             (state_r != ST_IDLE && !regWdata[`OSTSC_OS_START] &&
              regWr && hit(regAddr, `OSTSC_OFF_OSCTL)))) begin
            // reload and halt; count is lost past this point
            pre_r <= presc_r;
            cnt_r <= priRld_r;
            // a cleared start or one-shot bit ends any shot in flight
            state_r <= ST_IDLE;
         end else if (srcTick && running_r &&
                      (!oneShotMode || state_r == ST_FIRE)) begin
            // ticks before running_r rises are not counted
            if (pre_r != 8'h00) begin
               pre_r <= pre_r - 8'h01;
            end else begin
               pre_r <= presc_r;
               if (cnt_r != 8'h00)
                  cnt_r <= cnt_r - 8'h01;
               else begin
                  cnt_r <= priRld_r;
                  underflow <= 1'b1;
                  if (oneShotMode)
                     state_r <= ST_IDLE;
               end
            end
         end
      end
   end

   // ****************************************************************
   // pulse output
   // ****************************************************************
   // active level is the inverse of the idle level
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         pulseOut <= 1'b0;
      else if (clkEn)
         pulseOut <= pum_r[`OSTSC_PUM_LEVEL] ^
                     (state_nxt == ST_FIRE && running_r);
   end

   // ****************************************************************
   // register reads
   // ****************************************************************
   // byte-wide: the 8-bit count is read in one access
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         regRdata <= 8'h00;
      else if (clkEn) begin
         regRdata <= 8'h00;
         if (regRd) begin
            case (regAddr)
               `OSTSC_OFF_MODE:
                  regRdata <= mode_r | {running_r, 7'h00};
               `OSTSC_OFF_PRESC: regRdata <= pre_r;
               `OSTSC_OFF_SECRLD: regRdata <= secRld_r;
               `OSTSC_OFF_PRIRLD: regRdata <= priRld_r;
               `OSTSC_OFF_OSCTL: regRdata <= {7'h00, osReq_r};
               `OSTSC_OFF_PUM: regRdata <= pum_r;
               `OSTSC_OFF_CNT: regRdata <= cnt_r;
               default: regRdata <= 8'h00;
            endcase
         end
      end
   end
endmodule

// ---- bench/ostsc_sva.sv ----
// Purpose: port checks of ostsc_top
// Assumes: mirror frozen with clkEn, no tick on a write edge
// Notes: start/stop state is mirrored from writes and ticks
`timescale 1ns/100ps
`include "ostsc_defs.vh"
module ostsc_sva #(parameter DW = 8) (
   input wire sys_clk,
   input wire nrst,
   input wire clkEn,
   input wire srcTick,
   input wire [`OSTSC_ADDR_W-1:0] regAddr,
   input wire [DW-1:0] regWdata,
   input wire regWr,
   input wire regRd,
   input wire [DW-1:0] regRdata,
   input wire extPin,
   input wire pulseOut,
   input wire underflow
);
   reg req_r, run_r, lvl_r, ten_r, os_r;
   reg [1:0] mode_r, quiet_r;
   // ****************************************************************
   // mirror of software state; quiet_r lets registered outputs settle
   // ****************************************************************
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         {req_r, run_r, lvl_r, ten_r, os_r} <= 5'h0;
         mode_r <= 2'h0;
         quiet_r <= 2'h0;
      end else if (clkEn) begin
         if (srcTick) run_r <= req_r;
         quiet_r <= regWr ? 2'h0 : quiet_r + {1'b0, quiet_r != 2'h3};
         if (regWr && regAddr == 3'h0) {req_r, mode_r} <= {regWdata[7], regWdata[5:4]};
         if (regWr && regAddr == 3'h5) {ten_r, lvl_r} <= regWdata[1:0];
         if (regWr && regAddr == 3'h4) os_r <= regWdata[0];
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   AST_RD_IDLE: assert property (!regRd |=> regRdata == '0)
      else $error("read data not zero outside read");
   AST_RD_UNMAPPED: assert property (regRd && regAddr == 3'h7 |=> regRdata == '0)
      else $error("unmapped read not zero");
   AST_RESET_IDLE: assert property (!$past(nrst) |-> !pulseOut && !underflow)
      else $error("outputs active after reset");
   AST_START_LAG: assert property (regRd && regAddr == 3'h0 && !mode_r[1] && req_r && !run_r |=> !regRdata[7])
      else $error("start bit read 1 before tick");
   AST_RUN_READS: assert property (regRd && regAddr == 3'h0 && !mode_r[1] && run_r |=> regRdata[7])
      else $error("start bit read 0 while running");
   AST_IDLE_LEVEL: assert property (quiet_r == 2'h3 && !req_r && !run_r && !$past(run_r) |-> pulseOut == lvl_r)
      else $error("idle level wrong");
   AST_NO_TRIG: assert property (quiet_r == 2'h3 && mode_r[1] && !ten_r && !os_r |-> pulseOut == lvl_r)
      else $error("pulse without trigger");
   AST_NO_UFLOW: assert property (!run_r && !$past(run_r) && !$past(run_r, 2) |-> !underflow)
      else $error("wrap while stopped");
   cover property (regRd && regAddr == 3'h0 && req_r && !run_r);
   cover property (run_r && !req_r);
   cover property ($rose(pulseOut));
endmodule
bind ostsc_top ostsc_sva #(.DW(DW)) chk_i (.sys_clk(sys_clk), .nrst(nrst),
   .clkEn(clkEn), .srcTick(srcTick), .regAddr(regAddr), .regWdata(regWdata),
   .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extPin(extPin),
   .pulseOut(pulseOut), .underflow(underflow));

// ---- bench/ostsc_tb_top.sv ----
// Purpose: self-checking bench of ostsc_top
// Assumes: clkEn high but for one freeze check, ticks made by hand
// Notes: ticks never share an edge with a write
`timescale 1ns/100ps
module ostsc_tb_top;
   reg sys_clk = 1'b0;
   reg nrst = 1'b0;
   reg srcTick = 1'b0;
   reg [2:0] regAddr = 3'h0;
   reg [7:0] regWdata = 8'h00;
   reg regWr = 1'b0;
   reg regRd = 1'b0;
   reg extPin = 1'b0;
   reg clkEn = 1'b1;
   wire [7:0] regRdata;
   wire pulseOut, underflow;
   integer fail_count = 0;
   integer checks = 0;
   // ****************************************************************
   // clock, device and bus tasks
   // ****************************************************************
   always #2 sys_clk = ~sys_clk;
   ostsc_top dut (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn),
      .srcTick(srcTick), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extPin(extPin),
      .pulseOut(pulseOut), .underflow(underflow));
   task chk(input [8*5:1] nm, input [7:0] e, input [7:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            fail_count = fail_count + 1;
            $display("MISMATCH %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task wr(input [2:0] a, input [7:0] d);
      begin
         regAddr <= a;
         regWdata <= d;
         regWr <= 1'b1;
         @(posedge sys_clk);
         regWr <= 1'b0;
         // idle edge: a following write never re-raises the strobe at once
         @(posedge sys_clk);
      end
   endtask
   // read data stand only in the cycle after the strobe
   task rc(input [8*5:1] nm, input [2:0] a, input [7:0] m, input [7:0] e);
      begin
         regAddr <= a;
         regRd <= 1'b1;
         @(posedge sys_clk);
         regRd <= 1'b0;
         @(negedge sys_clk);
         chk(nm, e, regRdata & m);
         @(posedge sys_clk);
      end
   endtask
   task tick;
      begin
         srcTick <= 1'b1;
         @(posedge sys_clk);
         srcTick <= 1'b0;
         @(posedge sys_clk);
      end
   endtask
   task t_reset;
      begin
         rc("mode", 3'h0, 8'hFF, 8'h00);
         rc("pum", 3'h5, 8'hFF, 8'h00);
         rc("sec", 3'h2, 8'hFF, 8'hFF);
         wr(3'h7, 8'h5A);
         rc("unmap", 3'h7, 8'hFF, 8'h00);
         wr(3'h5, 8'h05);
         rc("pum", 3'h5, 8'h07, 8'h05);
         repeat (4) @(negedge sys_clk);
         chk("idle", 8'h01, {7'h0, pulseOut});
         @(posedge sys_clk);
         wr(3'h5, 8'h00);
      end
   endtask
   task t_start;
      begin
         wr(3'h0, 8'h80);
         rc("start", 3'h0, 8'h80, 8'h00);
         // a tick while frozen must leave the start bit lagging
         clkEn <= 1'b0;
         tick;
         clkEn <= 1'b1;
         rc("frz", 3'h0, 8'h80, 8'h00);
         tick;
         rc("start", 3'h0, 8'h80, 8'h80);
         wr(3'h0, 8'h00);
         rc("stop", 3'h0, 8'h80, 8'h80);
         tick;
         rc("stop", 3'h0, 8'h80, 8'h00);
      end
   endtask
   // one-shot fired, or not, by a pin edge while running
   task shot(input [7:0] pulse_output_mode, input rise, input ex);
      integer i;
      reg hit;
      reg uf;
      begin
         hit = 1'b0;
         uf = 1'b0;
         extPin <= ~rise;
         wr(3'h3, 8'h02);
         wr(3'h1, 8'h01);
         wr(3'h5, pulse_output_mode & 8'hFD);
         wr(3'h5, pulse_output_mode);
         wr(3'h0, 8'h20);
         wr(3'h0, 8'hA0);
         tick;
         extPin <= rise;
         for (i = 0; i < 80; i = i + 1) begin
            srcTick <= i[0];
            @(negedge sys_clk);
            if (pulseOut !== pulse_output_mode[0]) hit = 1'b1;
            if (underflow === 1'b1) uf = 1'b1;
            @(posedge sys_clk);
         end
         srcTick <= 1'b0;
         chk("shot", {7'h0, ex}, {7'h0, hit});
         chk("uflow", {7'h0, ex}, {7'h0, uf});
         wr(3'h0, 8'h20);
         tick;
         rc("stop", 3'h0, 8'h80, 8'h00);
         rc("cnt", 3'h6, 8'hFF, 8'h02);
         wr(3'h5, 8'h00);
      end
   endtask
   // wait mode shot fired by the one-shot start bit, then cut by clearing it
   task t_osctl;
      begin
         wr(3'h0, 8'h30);
         wr(3'h0, 8'hB0);
         tick;
         rc("start", 3'h0, 8'h80, 8'h80);
         wr(3'h4, 8'h01);
         rc("os", 3'h4, 8'h01, 8'h01);
         repeat (3) tick;
         @(negedge sys_clk);
         chk("fire", 8'h01, {7'h0, pulseOut});
         @(posedge sys_clk);
         rc("cnt", 3'h6, 8'hFF, 8'h01);
         wr(3'h4, 8'h00);
         rc("cnt", 3'h6, 8'hFF, 8'h02);
         @(negedge sys_clk);
         chk("halt", 8'h00, {7'h0, pulseOut});
         @(posedge sys_clk);
         wr(3'h0, 8'h30);
         tick;
         rc("stop", 3'h0, 8'h80, 8'h00);
      end
   endtask
   task summarize;
      begin
         if (fail_count == 0 && checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   // ****************************************************************
   // main sequence and watchdog
   // ****************************************************************
   initial begin
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      t_reset;
      t_start;
      shot(8'h06, 1'b1, 1'b1);
      shot(8'h03, 1'b0, 1'b1);
      shot(8'h06, 1'b0, 1'b0);
      shot(8'h04, 1'b1, 1'b0);
      t_osctl;
      summarize;
   end
   initial begin
      #40000;
      fail_count = fail_count + 1;
      summarize;
   end
endmodule
